/* File: shared/swlp_pkg.sv */
// Purpose: Shared constants for the serial word load port.
// Assumes: A 24-bit word whose two least significant bits pick one of four latches.
// Notes:   Field positions inside the function latch are fixed here and used by rtl/.

package swlp_pkg;

    // ------------------------------------------------------------
    // Word and latch geometry
    // ------------------------------------------------------------
    localparam int WORD_W = 24;
    localparam int CTRL_W = 2;
    localparam int NUM_LATCH = 4;
    localparam logic [WORD_W-1:0] LATCH_RESET = 24'h00_0000;

    // ------------------------------------------------------------
    // Latch addresses carried in the control bits
    // ------------------------------------------------------------
    localparam logic [CTRL_W-1:0] ADDR_REF_LATCH = 2'h0;
    localparam logic [CTRL_W-1:0] ADDR_DIV_LATCH = 2'h1;
    localparam logic [CTRL_W-1:0] ADDR_FUNC_LATCH = 2'h2;
    localparam logic [CTRL_W-1:0] ADDR_INIT_LATCH = 2'h3;

    // ------------------------------------------------------------
    // Function latch fields
    // ------------------------------------------------------------
    localparam int PD_BIT_POS = 3;
    localparam int OBS_SEL_LSB = 4;
    localparam int OBS_SEL_W = 3;
    localparam logic [OBS_SEL_W-1:0] OBS_LOCK = 3'h1;
    localparam logic [OBS_SEL_W-1:0] OBS_RF_DIV = 3'h2;
    localparam logic [OBS_SEL_W-1:0] OBS_REF_DIV = 3'h4;

    // ------------------------------------------------------------
    // Synchroniser depth and power states
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        SWLP_PWR_DOWN = 2'b01,
        SWLP_PWR_UP = 2'b10
    } swlp_pwr_e;

endpackage : swlp_pkg

/* File: rtl/swlp_sync.sv */
// Purpose: Two-flop level synchroniser for pins entering the clk domain.
// Assumes: Each bit is a slow level; no bus coherency between bits is needed.
// Notes:   Only the second stage is visible outside.

`timescale 1ns/1ps
`default_nettype none

module swlp_sync
    import swlp_pkg::*;
#(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
        if (!rst_n) begin
            meta_next = '0;
            sync_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
    end

    assign sync_out = sync_reg;

endmodule : swlp_sync

`default_nettype wire

/* File: rtl/swlp_port.sv */
// Purpose: Three-wire serial load port with four word latches, power gating
//          and the observation multiplexer.
// Assumes: The serial clock is a clock of its own; the strobe and chip power
//          pin are synchronised into clk before use.
// Notes:   The shifted word is read across domains only after the strobe rises.
//
// Summary of operation
// - Each rising serial clock edge shifts the data pin into a 24-bit register.
// - A rising load strobe copies the word into the one latch its control bits name.
// - A low chip power pin keeps the device down with the pump output in three-state.
// - A high chip power pin powers up only if the power-down bit is clear.
// - The observation output shows lock detect, divided RF or divided reference.

`timescale 1ns/1ps
`default_nettype none

module swlp_port
    import swlp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic latch_load_strobe,
    input wire logic chip_power,
    input wire logic lock_detect_in,
    input wire logic rf_div_in,
    input wire logic ref_div_in,
    input wire logic pump_drive_in,
    output logic pump_current_output,
    output logic pump_output_enable,
    output logic device_powered,
    output logic observe_select_output,
    output logic [WORD_W-1:0] ref_latch_word,
    output logic [WORD_W-1:0] div_latch_word,
    output logic [WORD_W-1:0] func_latch_word,
    output logic [WORD_W-1:0] init_latch_word
);

    // ------------------------------------------------------------
    // Serial clock domain: shift register
    // ------------------------------------------------------------
    // No reset here: the serial clock may stand still, and the shift
    // register holds only data until a strobe qualifies it.
    logic [WORD_W-1:0] shift_reg;
    logic [WORD_W-1:0] shift_next;

    always_comb begin
        // The newest bit enters at the bottom, so the last two bits sent
        // end up as the control field.
        shift_next = {shift_reg[WORD_W-2:0], serial_data};
    end

    always_ff @(posedge serial_clk) begin
        shift_reg <= shift_next;
    end

    // The register has no reset, so the check waits until a whole word has
    // been shifted in; before that the bits it compares are undefined.
    a_shift_capture: assert property (@(posedge serial_clk)
        1'b1 ##23 1'b1 |=> shift_reg[0] == $past(serial_data) &&
        shift_reg[WORD_W-1:1] == $past(shift_reg[WORD_W-2:0]))
        else $error("shift register did not take the data pin");

    // ------------------------------------------------------------
    // Pin synchronisation into clk
    // ------------------------------------------------------------
    logic [1:0] pins_sync;
    logic strobe_sync;
    logic ce_sync;

    swlp_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({latch_load_strobe, chip_power}),
        .sync_out(pins_sync)
    );

    assign strobe_sync = pins_sync[1];
    assign ce_sync = pins_sync[0];

    // ------------------------------------------------------------
    // Strobe edge detection
    // ------------------------------------------------------------
    logic strobe_prev_reg;
    logic strobe_prev_next;
    logic load_pulse;

    always_comb begin
        strobe_prev_next = rst_n ? strobe_sync : 1'b0;
    end

    always_ff @(posedge clk) begin
        strobe_prev_reg <= strobe_prev_next;
    end

    assign load_pulse = rst_n && strobe_sync && !strobe_prev_reg;

    // ------------------------------------------------------------
    // Word latches
    // ------------------------------------------------------------
    // The word crosses from the serial domain as a whole. It is safe
    // because the serial clock is idle around the strobe, so the shift
    // register is stable for the few clk cycles the synchroniser takes.
    logic [CTRL_W-1:0] load_addr;
    logic [NUM_LATCH-1:0] write_en;
    logic [WORD_W-1:0] latch_reg [NUM_LATCH];
    logic [WORD_W-1:0] latch_next [NUM_LATCH];

    assign load_addr = shift_reg[CTRL_W-1:0];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LATCH; gi++) begin : g_latch
            assign write_en[gi] = load_pulse && (load_addr == CTRL_W'(gi));

            always_comb begin
                latch_next[gi] = latch_reg[gi];
                if (!rst_n) begin
                    latch_next[gi] = LATCH_RESET;
                end else if (write_en[gi]) begin
                    latch_next[gi] = shift_reg;
                end
            end

            always_ff @(posedge clk) begin
                latch_reg[gi] <= latch_next[gi];
            end

            a_latch_takes_word: assert property (@(posedge clk) disable iff (!rst_n)
                write_en[gi] |=> latch_reg[gi] == $past(shift_reg))
                else $error("addressed latch did not take the shifted word");

            a_latch_holds: assert property (@(posedge clk) disable iff (!rst_n)
                !write_en[gi] |=> $stable(latch_reg[gi]))
                else $error("latch changed without a load to its address");
        end
    endgenerate

    assign ref_latch_word = latch_reg[ADDR_REF_LATCH];
    assign div_latch_word = latch_reg[ADDR_DIV_LATCH];
    assign func_latch_word = latch_reg[ADDR_FUNC_LATCH];
    assign init_latch_word = latch_reg[ADDR_INIT_LATCH];

    a_one_latch_loaded: assert property (@(posedge clk) disable iff (!rst_n)
        load_pulse |-> $onehot(write_en) && write_en[load_addr])
        else $error("a load did not select exactly one latch");

    a_load_on_edge: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(strobe_sync) |-> load_pulse ##1 !load_pulse)
        else $error("strobe edge did not give a single load");

    // ------------------------------------------------------------
    // Power control
    // ------------------------------------------------------------
    logic powerdown_bit;
    swlp_pwr_e pwr_reg;
    swlp_pwr_e pwr_next;

    assign powerdown_bit = latch_reg[ADDR_FUNC_LATCH][PD_BIT_POS];

    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            SWLP_PWR_DOWN: begin
                if (ce_sync && !powerdown_bit) begin
                    pwr_next = SWLP_PWR_UP;
                end
            end
            SWLP_PWR_UP: begin
                if (!ce_sync || powerdown_bit) begin
                    pwr_next = SWLP_PWR_DOWN;
                end
            end
            default: begin
                pwr_next = SWLP_PWR_DOWN;
            end
        endcase
        if (!rst_n) begin
            pwr_next = SWLP_PWR_DOWN;
        end
    end

    always_ff @(posedge clk) begin
        pwr_reg <= pwr_next;
    end

    assign device_powered = (pwr_reg == SWLP_PWR_UP);

    a_pin_low_down: assert property (@(posedge clk) disable iff (!rst_n)
        !ce_sync |=> !device_powered && !pump_output_enable)
        else $error("device stayed up with chip power low");

    a_power_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (ce_sync && !powerdown_bit) |=> device_powered)
        else $error("device did not power up with the bit clear");

    a_soft_down: assert property (@(posedge clk) disable iff (!rst_n)
        powerdown_bit |=> !device_powered)
        else $error("device powered up against the power-down bit");

    // ------------------------------------------------------------
    // Charge pump output
    // ------------------------------------------------------------
    // The enable follows the power state one cycle later, except that a low chip power pin
    // drops it in the same cycle as the power state; the pump drive
    // is forced low while disabled so nothing stale leaks on re-enable.
    logic pump_oe_reg;
    logic pump_oe_next;
    logic pump_out_reg;
    logic pump_out_next;

    always_comb begin
        pump_oe_next = rst_n && ce_sync && device_powered;
        pump_out_next = pump_oe_next && pump_drive_in;
    end

    always_ff @(posedge clk) begin
        pump_oe_reg <= pump_oe_next;
        pump_out_reg <= pump_out_next;
    end

    assign pump_output_enable = pump_oe_reg;
    assign pump_current_output = pump_out_reg;

    a_pump_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        !pump_output_enable |-> !pump_current_output)
        else $error("pump drove while in three-state");

    // ------------------------------------------------------------
    // Observation multiplexer
    // ------------------------------------------------------------
    // Unused select codes drive low rather than an arbitrary source.
    logic [OBS_SEL_W-1:0] obs_sel;
    logic obs_reg;
    logic obs_next;

    assign obs_sel = latch_reg[ADDR_FUNC_LATCH][OBS_SEL_LSB +: OBS_SEL_W];

    always_comb begin
        obs_next = 1'b0;
        if (rst_n) begin
            unique case (obs_sel)
                OBS_LOCK: obs_next = lock_detect_in;
                OBS_RF_DIV: obs_next = rf_div_in;
                OBS_REF_DIV: obs_next = ref_div_in;
                default: obs_next = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        obs_reg <= obs_next;
    end

    assign observe_select_output = obs_reg;

    a_observe_lock: assert property (@(posedge clk) disable iff (!rst_n)
        obs_sel == OBS_LOCK |=> observe_select_output == $past(lock_detect_in))
        else $error("observation output did not follow lock detect");

    a_observe_rf: assert property (@(posedge clk) disable iff (!rst_n)
        obs_sel == OBS_RF_DIV |=> observe_select_output == $past(rf_div_in))
        else $error("observation output did not follow divided RF");

    a_observe_ref: assert property (@(posedge clk) disable iff (!rst_n)
        obs_sel == OBS_REF_DIV |=> observe_select_output == $past(ref_div_in))
        else $error("observation output did not follow divided reference");

endmodule : swlp_port

`default_nettype wire

/* File: dv/swlp_host.sv */
// Purpose: Host controller model that shifts words into the load port.
// Assumes: The serial clock idles low between frames and runs at 32 ns.
// Notes:   Released data shows the inverse of its last bit, never a stale value.
`timescale 1ns/1ps
`default_nettype none

module swlp_host (
    output var logic serial_clk,
    output var logic serial_data,
    output var logic latch_load_strobe
);
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        latch_load_strobe = 1'b0;
    end

    // Sends the low n bits of v, then strobes when load is set.
    // The long gap after the strobe keeps the serial clock idle while the port reads.
    task automatic send(input logic [31:0] v, input int n, input bit load);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data = v[i];
            #16 serial_clk = 1'b1;
            #16 serial_clk = 1'b0;
        end
        serial_data = ~v[0];
        if (load) begin
            #16 latch_load_strobe = 1'b1;
            #40 latch_load_strobe = 1'b0;
        end
        #60;
    endtask : send
endmodule : swlp_host

`default_nettype wire

/* File: dv/test_serial_word_load_port.sv */
// Purpose: Self-checking bench for the serial word load port.
// Assumes: Each load settles in the gap the host leaves after its strobe.
// Notes:   Loads are noted in a queue and matched as latch words change.
`timescale 1ns/1ps
`default_nettype none

module test_serial_word_load_port;
    import swlp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic chip_power = 1'b0;
    logic [3:0] src = 4'h0;
    wire logic s_clk;
    wire logic s_data;
    wire logic strobe;
    logic pump_out;
    logic pump_en;
    logic powered;
    logic obs;
    logic [WORD_W-1:0] lw [NUM_LATCH];
    logic [WORD_W-1:0] model [NUM_LATCH] = '{default: '0};
    logic [WORD_W-1:0] prev [NUM_LATCH] = '{default: '0};
    logic [WORD_W-1:0] notes [$];
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    swlp_host host (.serial_clk(s_clk), .serial_data(s_data), .latch_load_strobe(strobe));

    swlp_port DUT (
        .clk(clk), .rst_n(rst_n), .serial_clk(s_clk), .serial_data(s_data),
        .latch_load_strobe(strobe), .chip_power(chip_power),
        .lock_detect_in(src[3]), .rf_div_in(src[2]), .ref_div_in(src[1]),
        .pump_drive_in(src[0]), .pump_current_output(pump_out),
        .pump_output_enable(pump_en), .device_powered(powered),
        .observe_select_output(obs), .ref_latch_word(lw[0]), .div_latch_word(lw[1]),
        .func_latch_word(lw[2]), .init_latch_word(lw[3])
    );

    always #5 clk = ~clk;

    task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // A hang would otherwise keep the run going forever.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            complete_run();
        end
    end

    // Any latch change takes the oldest note; every latch is then compared.
    always @(negedge clk) begin : watch
        bit hit;
        logic [WORD_W-1:0] w;
        hit = 1'b0;
        for (int a = 0; a < NUM_LATCH; a++) begin
            hit = hit | (lw[a] !== prev[a]);
            prev[a] = lw[a];
        end
        if (rst_n && hit) begin
            if (notes.size() > 0) begin
                w = notes.pop_front();
                model[w[1:0]] = w;
            end
            for (int a = 0; a < NUM_LATCH; a++) begin
                check(lw[a], model[a]);
            end
        end
    end

    function automatic logic exp_obs(input logic [OBS_SEL_W-1:0] sel, input logic [3:0] r);
        if (sel == OBS_LOCK) return r[3];
        if (sel == OBS_RF_DIV) return r[2];
        if (sel == OBS_REF_DIV) return r[1];
        return 1'b0;
    endfunction : exp_obs

    task automatic load_func(input logic pd, input logic [OBS_SEL_W-1:0] sel);
        logic [WORD_W-1:0] w;
        w = {(WORD_W-CTRL_W)'($urandom()), ADDR_FUNC_LATCH};
        w[PD_BIT_POS] = pd;
        w[OBS_SEL_LSB +: OBS_SEL_W] = sel;
        notes.push_back(w);
        host.send(32'(w), WORD_W, 1'b1);
    endtask : load_func

    task automatic wait_pwr(input logic exp);
        for (int i = 0; i < 12 && powered !== exp; i++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        check(powered, exp);
        check(pump_en, exp);
    endtask : wait_pwr

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        logic [WORD_W-1:0] w;
        logic [31:0] v;
        logic [3:0] r;
        logic [OBS_SEL_W-1:0] codes [4];
        codes = '{OBS_LOCK, OBS_RF_DIV, OBS_REF_DIV, 3'h7};
        void'($urandom(32'he8f3def0));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check(powered, 1'b0);
        check(pump_en, 1'b0);
        for (int a = 0; a < NUM_LATCH; a++) check(lw[a], LATCH_RESET);
        for (int k = 0; k < 8; k++) begin
            w = {(WORD_W-CTRL_W)'($urandom()), 2'(k)};
            notes.push_back(w);
            host.send(32'(w), WORD_W, 1'b1);
        end
        // Extra leading bits must fall off the top of the shift register.
        w = WORD_W'($urandom());
        notes.push_back(w);
        host.send({4'ha, 4'h0, w}, 28, 1'b1);
        // Shifting alone changes nothing; a bare strobe then loads the held word.
        v = $urandom();
        host.send(v, WORD_W, 1'b0);
        repeat (10) @(posedge clk);
        #1;
        for (int a = 0; a < NUM_LATCH; a++) check(lw[a], model[a]);
        notes.push_back(v[WORD_W-1:0]);
        host.send(32'h0, 0, 1'b1);
        load_func(1'b0, OBS_LOCK);
        wait_pwr(1'b0);
        @(posedge clk);
        chip_power <= 1'b1;
        wait_pwr(1'b1);
        foreach (codes[c]) begin
            load_func(1'b0, codes[c]);
            repeat (16) begin
                @(posedge clk);
                r = 4'($urandom());
                src <= r;
                @(posedge clk);
                #1;
                check(obs, exp_obs(codes[c], r));
                check(pump_out, r[0]);
            end
        end
        load_func(1'b1, OBS_LOCK);
        wait_pwr(1'b0);
        load_func(1'b0, OBS_LOCK);
        wait_pwr(1'b1);
        @(posedge clk);
        src <= 4'hf;
        chip_power <= 1'b0;
        wait_pwr(1'b0);
        check(pump_out, 1'b0);
        check(WORD_W'(notes.size()), '0);
        complete_run();
    end
endmodule : test_serial_word_load_port

`default_nettype wire
